// File: jnp_port.sv
// Test-access port logic for streaming programming of on-chip flash
//
// Contract
// - Port usable only with enable fuse programmed and disable bit clear.
// - Disable bit set and external reset low: bit clears after two clocks.
// - All shift registers shift least significant bit first, in and out.
// - Instruction register is four bits wide.
// - Code 0xC selects one-bit reset chain; test state machine unaffected.
// - A one in reset chain holds core reset immediately, unlatched.
// - Core stays reset for fuse-selected time-out after chain release.
// - Code 0x4 selects 16-bit unlock register, compared on Update-DR.
// - Unlock signature is the fixed binary value 1010_0011_0111_0000.
// - Unlock register clears on power-on reset; programmer clears on exit.
// - Code 0x5 selects 15-bit command register; capture loads previous result.
// - Update-DR applies command; each Run-Test/Idle visit executes one cycle.
// - Code 0x6 selects byte register, low bits of command register.
// - Page-load update copies byte to temporary, written within eleven TCK; here it waits while the FIFO is full.
// - Page-load updates alternate low then high byte, low first.
// - Counter pre-increments before each low-byte write except the first.
// - Code 0x7 captures flash bytes alternating low then high, low first.
// - Counter post-increments after every high-byte capture, including first.
`timescale 1ns/1ps
`default_nettype none
`include "jnp_defines.svh"
module jnp_port #(
  parameter int P_TIMEOUT_FAST = 64,
  parameter int P_TIMEOUT_SLOW = 16384
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_ce,
  input  wire logic                   i_tck,
  input  wire logic                   i_tms,
  input  wire logic                   i_tdi,
  output logic                        o_tdo,
  output logic                        o_tdo_oe,
  input  wire logic                   i_test_port_enable_fuse,
  input  wire logic                   i_clk_opt_slow,
  input  wire logic                   i_ext_rst_n,
  input  wire logic                   i_disable_wr,
  input  wire logic                   i_disable_wdata,
  output logic                        o_test_port_disable_bit,
  output logic                        o_core_rst,
  output logic                        o_prog_mode,
  output logic [`JNP_CMD_W-1:0]       o_flash_cmd,
  output logic                        o_flash_exec,
  input  wire logic [`JNP_CMD_W-1:0]  i_flash_result,
  input  wire logic                   i_addr_load,
  input  wire logic [`JNP_PC_W-1:0]   i_addr_value,
  output logic [`JNP_PC_W-1:0]        o_pc,
  input  wire logic [`JNP_PC_W-1:0]   i_read_word,
  output logic                        o_pbuf_valid,
  input  wire logic                   i_pbuf_ready,
  output jnp_pkg::jnp_word_t          o_pbuf_data,
  output logic                        o_pload_ready
);
  import jnp_pkg::*;

  // ========================================================================
  // Pin synchronisers
  logic [1:0] tck_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;
  logic [1:0] xrst_sync;
  logic       tck_prev;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tck_sync  <= 2'h0;
      tms_sync  <= 2'h3;
      tdi_sync  <= 2'h3;
      xrst_sync <= 2'h3;
      tck_prev  <= 1'b0;
    end else if (i_ce) begin
      tck_sync  <= {tck_sync[0], i_tck};
      tms_sync  <= {tms_sync[0], i_tms};
      tdi_sync  <= {tdi_sync[0], i_tdi};
      xrst_sync <= {xrst_sync[0], i_ext_rst_n};
      tck_prev  <= tck_sync[1];
    end
  end

  wire tck_rise = i_ce & tck_sync[1] & ~tck_prev;
  wire tck_fall = i_ce & ~tck_sync[1] & tck_prev;
  wire tms      = tms_sync[1];
  wire tdi      = tdi_sync[1];
  wire ext_low  = ~xrst_sync[1];

  // ========================================================================
  // Port enable and disable bit
  logic                 disable_bit;
  logic [1:0]           dis_cnt;
  wire                  port_on = i_test_port_enable_fuse & ~disable_bit;
  wire                  dis_hw_clr = disable_bit & ext_low &
                                     (dis_cnt == 2'(`JNP_DIS_CLR_CLKS - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      disable_bit <= 1'b0;
      dis_cnt     <= 2'h0;
    end else if (i_ce) begin
      dis_cnt <= (disable_bit & ext_low & ~dis_hw_clr) ? dis_cnt + 2'h1 : 2'h0;
      if (i_disable_wr) begin
        disable_bit <= i_disable_wdata;
      end else if (dis_hw_clr) begin
        disable_bit <= 1'b0;
      end
    end
  end
  assign o_test_port_disable_bit = disable_bit;

  // ========================================================================
  // TAP state machine, advanced on each sampled TCK rise
  jnp_tap_e state;
  jnp_tap_e next_state;

  always_comb begin
    case (state)
      JNP_TLR:    next_state = tms ? JNP_TLR : JNP_RTI;
      JNP_RTI:    next_state = tms ? JNP_SEL_DR : JNP_RTI;
      JNP_SEL_DR: next_state = tms ? JNP_SEL_IR : JNP_CAP_DR;
      JNP_CAP_DR: next_state = tms ? JNP_EX1_DR : JNP_SH_DR;
      JNP_SH_DR:  next_state = tms ? JNP_EX1_DR : JNP_SH_DR;
      JNP_EX1_DR: next_state = tms ? JNP_UPD_DR : JNP_PA_DR;
      JNP_PA_DR:  next_state = tms ? JNP_EX2_DR : JNP_PA_DR;
      JNP_EX2_DR: next_state = tms ? JNP_UPD_DR : JNP_SH_DR;
      JNP_UPD_DR: next_state = tms ? JNP_SEL_DR : JNP_RTI;
      JNP_SEL_IR: next_state = tms ? JNP_TLR : JNP_CAP_IR;
      JNP_CAP_IR: next_state = tms ? JNP_EX1_IR : JNP_SH_IR;
      JNP_SH_IR:  next_state = tms ? JNP_EX1_IR : JNP_SH_IR;
      JNP_EX1_IR: next_state = tms ? JNP_UPD_IR : JNP_PA_IR;
      JNP_PA_IR:  next_state = tms ? JNP_EX2_IR : JNP_PA_IR;
      JNP_EX2_IR: next_state = tms ? JNP_UPD_IR : JNP_SH_IR;
      JNP_UPD_IR: next_state = tms ? JNP_SEL_DR : JNP_RTI;
      default:    next_state = JNP_TLR;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= JNP_TLR;
    end else if (i_ce) begin
      if (!port_on) begin
        state <= JNP_TLR;
      end else if (tck_rise) begin
        state <= next_state;
      end
    end
  end

  // ========================================================================
  // Event strobes, one clock wide, valid on the TCK rise that leaves a state
  wire ev_cap_dr = tck_rise & (state == JNP_CAP_DR);
  wire ev_sh_dr  = tck_rise & (state == JNP_SH_DR);
  wire ev_upd_dr = tck_rise & (state == JNP_UPD_DR);
  wire ev_cap_ir = tck_rise & (state == JNP_CAP_IR);
  wire ev_sh_ir  = tck_rise & (state == JNP_SH_IR);
  wire ev_upd_ir = tck_rise & (state == JNP_UPD_IR);
  wire ev_rti_in = tck_rise & (state != JNP_RTI) & (next_state == JNP_RTI);

  // ========================================================================
  // Instruction register
  logic [`JNP_IR_W-1:0] ir_shift;
  logic [`JNP_IR_W-1:0] ir;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ir_shift <= `JNP_IR_RESET_VAL;
      ir       <= `JNP_IR_RESET_VAL;
    end else if (i_ce) begin
      if (state == JNP_TLR) begin
        ir <= `JNP_IR_RESET_VAL;
      end else if (ev_upd_ir) begin
        ir <= ir_shift;
      end
      if (ev_cap_ir) begin
        ir_shift <= `JNP_IR_CAPTURE;
      end else if (ev_sh_ir) begin
        ir_shift <= {tdi, ir_shift[`JNP_IR_W-1:1]};
      end
    end
  end

  wire sel_reset   = (ir == `JNP_INS_RESET);
  wire sel_unlock  = (ir == `JNP_INS_UNLOCK);
  wire sel_command = (ir == `JNP_INS_COMMAND);
  wire sel_pload   = (ir == `JNP_INS_PLOAD);
  wire sel_pread   = (ir == `JNP_INS_PREAD);
  wire new_pload   = ev_upd_ir & (ir_shift == `JNP_INS_PLOAD);
  wire new_pread   = ev_upd_ir & (ir_shift == `JNP_INS_PREAD);

  wire [`JNP_LEN_W-1:0] dr_len = sel_unlock ? `JNP_LEN_UNLOCK :
                                 sel_command ? `JNP_LEN_COMMAND :
                                 (sel_pload | sel_pread) ? `JNP_LEN_BYTE :
                                 `JNP_LEN_BYPASS;

  // Shift toward bit 0 with new data entering at the top of the active length
  function automatic logic [`JNP_DR_W-1:0] shift_lsb(input logic [`JNP_DR_W-1:0] r,
                                                     input logic bit_in,
                                                     input logic [`JNP_LEN_W-1:0] len);
    logic [`JNP_DR_W-1:0] o;
    o = r;
    for (int i = 0; i < `JNP_DR_W; i++) begin
      if (i == int'(len) - 1) begin
        o[i] = bit_in;
      end else if (i < int'(len) - 1) begin
        o[i] = r[i + 1];
      end
    end
    return o;
  endfunction

  // ========================================================================
  // Shared data shift register; the byte registers are its low bits
  logic [`JNP_DR_W-1:0] dr;
  logic                 rst_chain;
  logic                 prog_mode;
  logic                 rd_high;
  wire  [`JNP_BYTE_W-1:0] rd_byte = rd_high ? i_read_word[`JNP_PC_W-1:`JNP_BYTE_W] :
                                              i_read_word[`JNP_BYTE_W-1:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dr        <= `JNP_UNLOCK_RST;
      rst_chain <= 1'b0;
    end else if (i_ce) begin
      if (ev_cap_dr & sel_command) begin
        dr <= {1'b0, i_flash_result};
      end else if (ev_cap_dr & sel_pread & prog_mode) begin
        dr <= {dr[`JNP_DR_W-1:`JNP_BYTE_W], rd_byte};
      end else if (ev_sh_dr & ~sel_reset) begin
        dr <= shift_lsb(dr, tdi, dr_len);
      end
      // Chain drives reset straight from the shift stage, no update latch
      if (ev_sh_dr & sel_reset) begin
        rst_chain <= tdi;
      end
    end
  end

  // ========================================================================
  // Programming mode and command application
  logic cmd_applied;
  // Execute sees the command applied on the same rise that enters idle
  wire  cmd_upd   = ev_upd_dr & sel_command & prog_mode;
  wire  next_prog = (ev_upd_dr & sel_unlock) ? (dr == `JNP_UNLOCK_SIG) : prog_mode;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog_mode    <= 1'b0;
      o_flash_cmd  <= '0;
      cmd_applied  <= 1'b0;
      o_flash_exec <= 1'b0;
    end else if (i_ce) begin
      o_flash_exec <= ev_rti_in & next_prog & (cmd_applied | cmd_upd);
      if (ev_upd_dr & sel_unlock) begin
        prog_mode <= (dr == `JNP_UNLOCK_SIG);
      end
      if (cmd_upd) begin
        o_flash_cmd <= dr[`JNP_CMD_W-1:0];
        cmd_applied <= 1'b1;
      end else if (~prog_mode) begin
        cmd_applied <= 1'b0;
      end
    end
  end
  assign o_prog_mode = prog_mode;

  // ========================================================================
  // Core reset with fuse-selected time-out after the chain releases
  logic [`JNP_CNT_W-1:0] to_cnt;
  wire  [`JNP_CNT_W-1:0] to_load = i_clk_opt_slow ? `JNP_CNT_W'(P_TIMEOUT_SLOW) :
                                                    `JNP_CNT_W'(P_TIMEOUT_FAST);
  wire                   rst_src = rst_chain | ext_low;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      to_cnt <= '0;
    end else if (i_ce) begin
      if (rst_src) begin
        to_cnt <= to_load;
      end else if (to_cnt != '0) begin
        to_cnt <= to_cnt - `JNP_CNT_W'(1);
      end
    end
  end
  assign o_core_rst = rst_src | (to_cnt != '0);

  // ========================================================================
  // Program counter and byte alternation for page load and page read
  logic pl_high;
  logic pl_first;
  logic pl_pending;
  logic [`JNP_PC_W-1:0] pc;
  logic [`JNP_PB_W-1:0] pl_word;

  wire ev_pl  = ev_upd_dr & sel_pload & prog_mode;
  wire pl_inc = ev_pl & ~pl_high & ~pl_first;
  wire [`JNP_PC_W-1:0] pl_addr = pl_inc ? pc + `JNP_PC_STEP : pc;
  wire rd_inc = ev_cap_dr & sel_pread & prog_mode & rd_high;

  jnp_stream_if #(.WIDTH(`JNP_PB_W)) fifo_in ();
  jnp_stream_if #(.WIDTH(`JNP_PB_W)) fifo_out ();

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc         <= '0;
      pl_high    <= 1'b0;
      pl_first   <= 1'b1;
      rd_high    <= 1'b0;
      pl_pending <= 1'b0;
      pl_word    <= '0;
    end else if (i_ce) begin
      if (i_addr_load) begin
        pc <= i_addr_value;
      end else if (pl_inc | rd_inc) begin
        pc <= pc + `JNP_PC_STEP;
      end
      if (new_pload) begin
        pl_high  <= 1'b0;
        pl_first <= 1'b1;
      end else if (ev_pl) begin
        pl_high  <= ~pl_high;
        pl_first <= 1'b0;
      end
      if (new_pread) begin
        rd_high <= 1'b0;
      end else if (ev_cap_dr & sel_pread & prog_mode) begin
        rd_high <= ~rd_high;
      end
      // Temporary byte; a new update before the FIFO takes it replaces it
      if (ev_pl) begin
        pl_word    <= {pl_high, pl_addr, dr[`JNP_BYTE_W-1:0]};
        pl_pending <= 1'b1;
      end else if (fifo_in.ready) begin
        pl_pending <= 1'b0;
      end
    end
  end
  assign o_pc = pc;

  // ========================================================================
  // Page-buffer FIFO; one clock to enter when not full, far below the TCK budget
  assign fifo_in.valid  = pl_pending;
  assign fifo_in.data   = pl_word;
  assign o_pbuf_valid   = fifo_out.valid;
  assign o_pbuf_data    = fifo_out.data;
  assign fifo_out.ready = i_pbuf_ready;
  assign o_pload_ready  = fifo_in.ready;

  jnp_fifo #(
    .WIDTH (`JNP_PB_W),
    .DEPTH (`JNP_FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .s_in    (fifo_in),
    .s_out   (fifo_out)
  );

  // ========================================================================
  // TDO launched on the sampled TCK fall, least significant bit out first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (i_ce) begin
      if (!port_on) begin
        o_tdo_oe <= 1'b0;
      end else if (tck_fall) begin
        o_tdo_oe <= (state == JNP_SH_DR) | (state == JNP_SH_IR);
        o_tdo    <= (state == JNP_SH_IR) ? ir_shift[0] :
                    sel_reset ? rst_chain : dr[0];
      end
    end
  end
endmodule
`default_nettype wire

// File: jnp_defines.svh
// Constants for the test-port programming block
`ifndef JNP_DEFINES_SVH
`define JNP_DEFINES_SVH

// ==========================================================================
// Instruction register
`define JNP_IR_W          4
`define JNP_IR_CAPTURE    4'h1
`define JNP_IR_RESET_VAL  4'hF
`define JNP_INS_RESET     4'hC
`define JNP_INS_UNLOCK    4'h4
`define JNP_INS_COMMAND   4'h5
`define JNP_INS_PLOAD     4'h6
`define JNP_INS_PREAD     4'h7

// ==========================================================================
// Data register lengths and values
`define JNP_DR_W          16
`define JNP_LEN_W         5
`define JNP_LEN_BYPASS    5'h01
`define JNP_LEN_RESET     5'h01
`define JNP_LEN_UNLOCK    5'h10
`define JNP_LEN_COMMAND   5'h0F
`define JNP_LEN_BYTE      5'h08
`define JNP_CMD_W         15
`define JNP_BYTE_W        8
`define JNP_PC_W          16
`define JNP_UNLOCK_SIG    16'hA370
`define JNP_UNLOCK_RST    16'h0000
`define JNP_PC_STEP       16'h0001

// ==========================================================================
// Timing
`define JNP_CLK_PERIOD_PS 5000
`define JNP_DIS_CLR_CLKS  2
`define JNP_CNT_W         16
`define JNP_PL_BUDGET_TCK 11

// ==========================================================================
// Page buffer stream: {high select, address, byte}
`define JNP_PB_W          25
`define JNP_FIFO_DEPTH    4

`endif

// File: jnp_pkg.sv
// Types shared by the test-port programming block
package jnp_pkg;
  `include "jnp_defines.svh"

  typedef enum logic [3:0] {
    JNP_TLR, JNP_RTI, JNP_SEL_DR, JNP_CAP_DR, JNP_SH_DR, JNP_EX1_DR, JNP_PA_DR,
    JNP_EX2_DR, JNP_UPD_DR, JNP_SEL_IR, JNP_CAP_IR, JNP_SH_IR, JNP_EX1_IR,
    JNP_PA_IR, JNP_EX2_IR, JNP_UPD_IR
  } jnp_tap_e;

  typedef logic [`JNP_PB_W-1:0] jnp_word_t;
endpackage

// File: jnp_stream_if.sv
// Valid/ready carrier between the port logic and its page-buffer FIFO
`timescale 1ns/1ps
`default_nettype none
interface jnp_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: jnp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module jnp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  jnp_stream_if.snk s_in,
  jnp_stream_if.src s_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = s_in.valid & s_in.ready & i_ce;
  wire pop  = s_out.valid & s_out.ready & i_ce;

  // Count is one bit wider than the pointers so that full reads as DEPTH
  assign s_in.ready  = (count != (AW + 1)'(DEPTH));
  assign s_out.valid = (count != '0);
  assign s_out.data  = mem[rd_ptr];

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= s_in.data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= step(wr_ptr);
      if (pop)  rd_ptr <= step(rd_ptr);
      if (push != pop) count <= push ? count + 1'b1 : count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: jnp_port_asserts.sv
// Pin-level checker for the test-port programming block
`timescale 1ns/1ps
`default_nettype none
`include "jnp_defines.svh"
module jnp_port_asserts
  import jnp_pkg::*;
#(
  parameter int P_TIMEOUT_FAST = 64,
  parameter int P_TIMEOUT_SLOW = 16384
) (
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_ce,
  input wire logic                  i_test_port_enable_fuse,
  input wire logic                  i_ext_rst_n,
  input wire logic                  i_disable_wr,
  input wire logic                  i_addr_load,
  input wire logic                  i_pbuf_ready,
  input wire logic                  o_tdo_oe,
  input wire logic                  o_test_port_disable_bit,
  input wire logic                  o_core_rst,
  input wire logic                  o_prog_mode,
  input wire logic [`JNP_CMD_W-1:0] o_flash_cmd,
  input wire logic                  o_flash_exec,
  input wire logic [`JNP_PC_W-1:0]  o_pc,
  input wire logic                  o_pbuf_valid,
  input wire jnp_pkg::jnp_word_t    o_pbuf_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========
  // Causes spanning several cycles; six covers the pin synchroniser
  sequence s_ext_low;
    (!i_ext_rst_n && !i_disable_wr && i_ce) [*6];
  endsequence
  sequence s_refused;
    (i_ce && (!i_test_port_enable_fuse || o_test_port_disable_bit)) [*3];
  endsequence
  // ==========
  // Checks
  a_ext_core_rst: assert property (s_ext_low |-> o_core_rst)
    else $error("core reset missing under external reset");
  a_dis_cleared: assert property (s_ext_low |=> !o_test_port_disable_bit)
    else $error("disable bit not cleared by external reset");
  a_refused_no_oe: assert property (s_refused |-> !o_tdo_oe)
    else $error("test data out driven while port refused");
  a_core_rst_hold: assert property ($rose(o_core_rst) |-> o_core_rst [*4])
    else $error("core reset released before time-out");
  a_exec_single: assert property (o_flash_exec |=> !o_flash_exec)
    else $error("execute pulse longer than one cycle");
  a_exec_locked: assert property (o_flash_exec |-> o_prog_mode)
    else $error("execute pulse outside programming mode");
  a_cmd_locked: assert property (!$stable(o_flash_cmd) |-> o_prog_mode)
    else $error("command applied outside programming mode");
  a_pc_step: assert property ((!$stable(o_pc) && !$past(i_addr_load))
    |-> o_pc == $past(o_pc) + `JNP_PC_STEP)
    else $error("program counter moved by other than one");
  a_pbuf_hold: assert property ((o_pbuf_valid && !i_pbuf_ready)
    |=> (o_pbuf_valid && $stable(o_pbuf_data)))
    else $error("page buffer word dropped while stalled");
endmodule
bind jnp_port jnp_port_asserts #(.P_TIMEOUT_FAST(P_TIMEOUT_FAST),
  .P_TIMEOUT_SLOW(P_TIMEOUT_SLOW)) u_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_test_port_enable_fuse(i_test_port_enable_fuse),
  .i_ext_rst_n(i_ext_rst_n), .i_disable_wr(i_disable_wr), .i_addr_load(i_addr_load),
  .i_pbuf_ready(i_pbuf_ready), .o_tdo_oe(o_tdo_oe),
  .o_test_port_disable_bit(o_test_port_disable_bit), .o_core_rst(o_core_rst),
  .o_prog_mode(o_prog_mode), .o_flash_cmd(o_flash_cmd), .o_flash_exec(o_flash_exec),
  .o_pc(o_pc), .o_pbuf_valid(o_pbuf_valid), .o_pbuf_data(o_pbuf_data));
`default_nettype wire

// File: jnp_prog_model.sv
// External programmer model driving three test pins and sampling TDO
`timescale 1ns/1ps
`default_nettype none
module jnp_prog_model (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // Only test pins move; 80 ns period stays far below the chip clock limit
  task automatic step(input logic m, input logic d, output logic q);
    o_tms = m;
    o_tdi = d;
    #40 o_tck = 1'b1;
    q = i_tdo;
    #40 o_tck = 1'b0;
    o_tdi = ~d;
  endtask
  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // From idle to idle; clock stands low between frames
  task automatic scan(input logic ir, input logic [15:0] din, input int n,
                      output logic [15:0] dout);
    logic q;
    #1.3;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule
`default_nettype wire

// File: tb_jtag_nvm_programming_port.sv
// Self-checking bench for the test-port programming block
`timescale 1ns/1ps
`default_nettype none
`include "jnp_defines.svh"
module tb_jtag_nvm_programming_port;
  import jnp_pkg::*;
  logic                  clk = 1'b0, rst_n = 1'b0, fuse = 1'b1, ext_n = 1'b1;
  logic                  dis_wr = 1'b0, dis_d = 1'b0, ld = 1'b0, pb_rdy = 1'b0;
  logic [`JNP_CMD_W-1:0] res = '0, cmd;
  logic [15:0]           addr = '0, pc, rword;
  logic                  tck, tms, tdi, tdo, tdo_w, tdo_oe, dis_bit, core_rst;
  logic                  prog, exec, pb_vld, pl_rdy, slow = 1'b1;
  jnp_word_t             pb_data;
  int                    err_count = 0, checks_done = 0, cyc = 0, exec_n = 0;
  always #2.5 clk = ~clk;
  // Flash word depends on address; tdo line pulled up when released
  assign rword = pc ^ 16'h5A3C;
  assign tdo_w = tdo_oe ? tdo : 1'b1;
  jnp_port #(.P_TIMEOUT_FAST(4), .P_TIMEOUT_SLOW(200)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_test_port_enable_fuse(fuse),
    .i_clk_opt_slow(slow), .i_ext_rst_n(ext_n), .i_disable_wr(dis_wr),
    .i_disable_wdata(dis_d), .o_test_port_disable_bit(dis_bit), .o_core_rst(core_rst),
    .o_prog_mode(prog), .o_flash_cmd(cmd), .o_flash_exec(exec), .i_flash_result(res),
    .i_addr_load(ld), .i_addr_value(addr), .o_pc(pc), .i_read_word(rword),
    .o_pbuf_valid(pb_vld), .i_pbuf_ready(pb_rdy), .o_pbuf_data(pb_data),
    .o_pload_ready(pl_rdy));
  jnp_prog_model PM (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_w));
  // ==========
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (exec === 1'b1) exec_n++;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic preset();
    @(posedge clk);
    addr <= 16'($urandom);
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  function automatic logic [7:0] rd_byte(input logic [15:0] a, input int k);
    logic [15:0] w;
    w = (a + 16'(k / 2)) ^ 16'h5A3C;
    return k[0] ? w[15:8] : w[7:0];
  endfunction
  // ==========
  // Scenarios
  initial begin
    logic [15:0] d, w;
    logic [7:0]  b [4];
    logic [14:0] c;
    int          e0, k;
    w = 16'($urandom(32'h8cc38dc3));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wclk(4);
    chk(prog, 1'b0);
    chk(pl_rdy, 1'b1);
    PM.reset_tap();
    PM.scan(1'b1, `JNP_INS_RESET, 4, d);
    chk(d[3:0], `JNP_IR_CAPTURE);
    PM.scan(1'b0, 16'h1, 1, d);
    chk(core_rst, 1'b1);
    PM.scan(1'b0, 16'h0, 1, d);
    chk(core_rst, 1'b1);
    wclk(200);
    chk(core_rst, 1'b0);
    PM.scan(1'b1, `JNP_INS_UNLOCK, 4, d);
    chk(d[3:0], `JNP_IR_CAPTURE);
    w = 16'($urandom);
    if (w == `JNP_UNLOCK_SIG) w = ~w;
    PM.scan(1'b0, w, 16, d);
    chk(prog, 1'b0);
    PM.scan(1'b0, `JNP_UNLOCK_SIG, 16, d);
    chk(prog, 1'b1);
    PM.scan(1'b1, `JNP_INS_COMMAND, 4, d);
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      res <= 15'($urandom);
      c = 15'($urandom);
      e0 = exec_n;
      PM.scan(1'b0, {1'b0, c}, 15, d);
      chk(d[14:0], res);
      chk(cmd, c);
      chk(exec_n - e0, 1);
    end
    // Page load into a stalled buffer until it refuses
    preset();
    PM.scan(1'b1, `JNP_INS_PLOAD, 4, d);
    for (k = 0; k < 4; k++) begin
      b[k] = 8'($urandom);
      PM.scan(1'b0, {8'h00, b[k]}, 8, d);
    end
    wclk(4);
    chk(pl_rdy, 1'b0);
    chk(pc, 16'(addr + 16'h1));
    k = 0;
    while (k < 4) begin
      @(negedge clk);
      if (pb_vld === 1'b1 && pb_rdy === 1'b1) begin
        chk(pb_data, {7'h00, k[0], addr + 16'(k / 2), b[k]});
        k++;
      end
      @(posedge clk);
      pb_rdy <= 1'($urandom);
    end
    wclk(2);
    chk(pb_vld, 1'b0);
    preset();
    PM.scan(1'b1, `JNP_INS_PREAD, 4, d);
    for (k = 0; k < 4; k++) begin
      PM.scan(1'b0, 16'h0, 8, d);
      chk(d[7:0], rd_byte(addr, k));
    end
    chk(pc, 16'(addr + 16'h2));
    // Disabled port, then reset-forced re-enable for in-system use
    @(posedge clk);
    dis_d <= 1'b1;
    dis_wr <= 1'b1;
    @(posedge clk);
    dis_wr <= 1'b0;
    wclk(2);
    PM.scan(1'b1, `JNP_INS_RESET, 4, d);
    chk(d[3:0], 4'hF);
    @(posedge clk);
    ext_n <= 1'b0;
    wclk(10);
    chk(dis_bit, 1'b0);
    chk(core_rst, 1'b1);
    ext_n <= 1'b1;
    fuse <= 1'b0;
    slow <= 1'b0;
    wclk(40);
    chk(core_rst, 1'b0);
    PM.scan(1'b1, `JNP_INS_RESET, 4, d);
    chk(d[3:0], 4'hF);
    @(posedge clk);
    fuse <= 1'b1;
    PM.reset_tap();
    PM.scan(1'b1, `JNP_INS_RESET, 4, d);
    chk(d[3:0], `JNP_IR_CAPTURE);
    end_of_test();
  end
endmodule
`default_nettype wire
